// [design/rci_hex_dec.sv]
// Hex character to nibble decoder
`timescale 1ns/10ps
module rci_hex_dec
   import rci_pkg::*;
(
   // Character in
   input  wire logic [7:0] hexChar,
   // Decoded value
   output logic      [3:0] nibble,
   output logic            isHex
);
   // Only digits and upper case A..F count as hex
   always_comb begin
      nibble = 4'h0;
      isHex  = 1'b0;
      if (hexChar >= 8'h30 && hexChar <= 8'h39) begin
         nibble = hexChar[3:0];
         isHex  = 1'b1;
      end else if (hexChar >= 8'h41 && hexChar <= 8'h46) begin
         nibble = 4'(hexChar[3:0] + 4'h9);
         isHex  = 1'b1;
      end
   end
endmodule

// [design/rci_hex_enc.sv]
// Nibble to hex character encoder
`timescale 1ns/10ps
module rci_hex_enc
   import rci_pkg::*;
(
   // Value in
   input  wire logic [3:0] nibble,
   // ASCII digit out
   output logic      [7:0] hexChar
);
   // Upper case letters, matching what the decoder accepts
   always_comb begin
      if (nibble < 4'ha) begin
         hexChar = {4'h3, nibble};
      end else begin
         hexChar = {4'h4, 4'(nibble - 4'h9)};
      end
   end
endmodule

// [design/rci_interp.sv]
// Escape sequence interpreter for remote configuration, memory and status line
// Notes on behaviour
// [RULE1] Escape character starts every command sequence
// [RULE2] Column sent as 32 plus n
// [RULE3] Row sent as 32 plus n, n up to 95
// [RULE4] Page sent as 32 plus n, n from 1
// [RULE5] ASCII write starts with four-digit hex address
// [RULE6] Two-digit hex byte count, up to 255
// [RULE7] ASCII write stores bit eight as zero
// [RULE8] Hex write count counts characters, not bytes
// [RULE9] Character pairs pack into bytes, 127 max
// [RULE10] Restart runs with new data, no commit
// [RULE11] Commit is accepted without prior restart
// [RULE12] Commit: off-line, store, back on-line local
// [RULE13] Readback takes address, count, enters transmit
// [RULE14] Readback sends each byte as two hex digits
// [RULE15] Status write fixed destination, 56 characters max
// [RULE16] Status message begins at column 17
// [RULE17] Unwritten status positions keep their contents
// [RULE18] Status write count zero clears message
// [RULE19] Hex digits 0-9, A-F; addresses increment
// [RULE20] After count consumed, resume normal handling
`timescale 1ns/10ps
module rci_interp
   import rci_pkg::*;
#(
   parameter int          CHARS_PER_LINE = CHARS_PER_LINE_DEF,
   parameter int          MAX_ROW        = MAX_ROW_DEF,
   parameter int          MAX_PAGES      = MAX_PAGES_DEF,
   parameter logic [15:0] STATUS_BASE    = STATUS_BASE_DEF
)(
   // Clock and reset
   input  wire logic        clock,
   input  wire logic        arst_n,
   // Received characters
   input  wire logic        rxValid,
   input  wire logic [7:0]  rxChar,
   output logic             rxReady,
   // Characters for normal handling
   output logic             passValid,
   output logic [7:0]       passChar,
   output logic             escFuncValid,
   output logic [7:0]       escFuncCode,
   // Cursor and page parameters
   output logic             cursorValid,
   output logic [6:0]       cursorCol,
   output logic [6:0]       cursorRow,
   output logic             pageValid,
   output logic [6:0]       pageSel,
   // Memory write port
   output logic             memWrEn,
   output logic [15:0]      memWrAddr,
   output logic [7:0]       memWrData,
   // Memory read port
   output logic             memRdReq,
   output logic [15:0]      memRdAddr,
   input  wire logic        memRdValid,
   input  wire logic [7:0]  memRdData,
   // Transmit characters
   output logic             txValid,
   output logic [7:0]       txChar,
   input  wire logic        txReady,
   output logic             xmitMode,
   // Configuration control
   output logic             restartReq,
   output logic             commitReq,
   input  wire logic        commitDone,
   output logic             offLine,
   output logic             localMode,
   input  wire logic        localKey
);
   initial begin
      if (CHARS_PER_LINE < 1 || CHARS_PER_LINE > 96 || MAX_ROW > 95 || MAX_ROW < 0
          || MAX_PAGES < 1 || MAX_PAGES > 95) begin
         $error("rci_interp: parameter out of range");
      end
   end

   rci_state_t  state_r, state_nxt;
   rci_cmd_t    cmd_r, cmd_nxt;
   logic [2:0]  dig_r, dig_nxt;
   logic [15:0] addr_r, addr_nxt;
   logic [7:0]  cnt_r, cnt_nxt;
   logic [7:0]  pos_r, pos_nxt;
   logic [3:0]  hiNib_r, hiNib_nxt;
   logic        half_r, half_nxt;
   logic [7:0]  rbByte_r, rbByte_nxt;
   logic [6:0]  col_r, col_nxt;
   logic        rxReady_r, rxReady_nxt;
   logic        passValid_r, passValid_nxt;
   logic [7:0]  passChar_r, passChar_nxt;
   logic        escValid_r, escValid_nxt;
   logic [7:0]  escCode_r, escCode_nxt;
   logic        curValid_r, curValid_nxt;
   logic [6:0]  curCol_r, curCol_nxt;
   logic [6:0]  curRow_r, curRow_nxt;
   logic        pgValid_r, pgValid_nxt;
   logic [6:0]  pgSel_r, pgSel_nxt;
   logic        wrEn_r, wrEn_nxt;
   logic [15:0] wrAddr_r, wrAddr_nxt;
   logic [7:0]  wrData_r, wrData_nxt;
   logic        rdReq_r, rdReq_nxt;
   logic        txValid_r, txValid_nxt;
   logic [7:0]  txChar_r, txChar_nxt;
   logic        restart_r, restart_nxt;
   logic        commit_r, commit_nxt;
   logic        offLine_r, offLine_nxt;
   logic        local_r, local_nxt;

   logic        take;
   logic [3:0]  rxNib;
   logic        rxIsHex;
   logic [3:0]  encIn;
   logic [7:0]  encChar;
   logic [7:0]  unbiased;

   rci_hex_dec uDec (
      .hexChar (rxChar),
      .nibble  (rxNib),
      .isHex   (rxIsHex)
   );

   // Encoder serves the high digit on read return, the low digit afterwards
   assign encIn = (state_r == ST_RB_WAIT) ? memRdData[7:4] : rbByte_r[3:0];

   rci_hex_enc uEnc (
      .nibble  (encIn),
      .hexChar (encChar)
   );

   assign take     = rxValid && rxReady_r;
   assign unbiased = 8'(rxChar - PARAM_BIAS);

   // Next-state and output computation
   always_comb begin
      state_nxt     = state_r;
      cmd_nxt       = cmd_r;
      dig_nxt       = dig_r;
      addr_nxt      = addr_r;
      cnt_nxt       = cnt_r;
      pos_nxt       = pos_r;
      hiNib_nxt     = hiNib_r;
      half_nxt      = half_r;
      rbByte_nxt    = rbByte_r;
      col_nxt       = col_r;
      passValid_nxt = 1'b0;
      passChar_nxt  = passChar_r;
      escValid_nxt  = 1'b0;
      escCode_nxt   = escCode_r;
      curValid_nxt  = 1'b0;
      curCol_nxt    = curCol_r;
      curRow_nxt    = curRow_r;
      pgValid_nxt   = 1'b0;
      pgSel_nxt     = pgSel_r;
      wrEn_nxt      = 1'b0;
      wrAddr_nxt    = wrAddr_r;
      wrData_nxt    = wrData_r;
      rdReq_nxt     = 1'b0;
      txValid_nxt   = txValid_r;
      txChar_nxt    = txChar_r;
      restart_nxt   = 1'b0;
      commit_nxt    = 1'b0;
      offLine_nxt   = offLine_r;
      local_nxt     = local_r;
      unique case (state_r)
         ST_IDLE: begin
            if (take) begin
               if (rxChar == CH_ESC) begin
                  state_nxt = ST_ESC; // RULE1
               end else begin
                  passValid_nxt = 1'b1;
                  passChar_nxt  = rxChar;
               end
            end else if (localKey) begin
               // Local key wipes the message area like a zero-count write
               pos_nxt   = 8'h00;
               state_nxt = ST_CLEAR; // RULE18
            end
         end
         ST_ESC: begin
            if (take) begin
               if (rxChar == CH_R) begin
                  state_nxt = ST_ESC_R;
               end else if (rxChar == CH_CURSOR) begin
                  state_nxt = ST_COL;
               end else if (rxChar == CH_PAGE) begin
                  state_nxt = ST_PAGE;
               end else begin
                  escValid_nxt = 1'b1;
                  escCode_nxt  = rxChar;
                  state_nxt    = ST_IDLE;
               end
            end
         end
         ST_COL: begin
            if (take) begin
               col_nxt   = (unbiased < 8'(CHARS_PER_LINE)) ? unbiased[6:0] : 7'h7f; // RULE2
               state_nxt = ST_ROW;
            end
         end
         ST_ROW: begin
            if (take) begin
               state_nxt = ST_IDLE;
               // Out-of-range positions are dropped rather than wrapped
               if (rxChar >= PARAM_BIAS && col_r < 7'(CHARS_PER_LINE)
                   && unbiased <= 8'(MAX_ROW)) begin // RULE3
                  curValid_nxt = 1'b1;
                  curCol_nxt   = col_r; // RULE2
                  curRow_nxt   = unbiased[6:0];
               end
            end
         end
         ST_PAGE: begin
            if (take) begin
               state_nxt = ST_IDLE;
               if (unbiased >= 8'h01 && unbiased <= 8'(MAX_PAGES)) begin // RULE4
                  pgValid_nxt = 1'b1;
                  pgSel_nxt   = unbiased[6:0];
               end
            end
         end
         ST_ESC_R: begin
            if (take) begin
               dig_nxt   = 3'h0;
               addr_nxt  = 16'h0000;
               cnt_nxt   = 8'h00;
               state_nxt = ST_ADDR;
               if (rxChar == CH_ASCII_WR) begin
                  cmd_nxt = CMD_ASCII; // RULE5
               end else if (rxChar == CH_HEX_WR) begin
                  cmd_nxt = CMD_HEX; // RULE8
               end else if (rxChar == CH_READBACK) begin
                  cmd_nxt = CMD_READ; // RULE13
               end else if (rxChar == CH_STATUS_WR) begin
                  cmd_nxt   = CMD_STAT; // RULE15
                  state_nxt = ST_CNT;
               end else if (rxChar == CH_RESTART) begin
                  restart_nxt = 1'b1; // RULE10
                  local_nxt   = 1'b0;
                  state_nxt   = ST_IDLE;
               end else if (rxChar == CH_COMMIT) begin
                  commit_nxt  = 1'b1; // RULE11
                  offLine_nxt = 1'b1; // RULE12
                  state_nxt   = ST_COMMIT;
               end else begin
                  state_nxt = ST_IDLE;
               end
            end
         end
         ST_ADDR: begin
            if (take) begin
               if (!rxIsHex) begin
                  state_nxt = ST_IDLE; // RULE19
               end else begin
                  addr_nxt = {addr_r[11:0], rxNib}; // RULE5
                  dig_nxt  = 3'(dig_r + 3'h1);
                  if (dig_r == 3'(ADDR_DIGITS - 3'h1)) begin
                     dig_nxt   = 3'h0;
                     state_nxt = ST_CNT;
                  end
               end
            end
         end
         ST_CNT: begin
            if (take) begin
               if (!rxIsHex) begin
                  state_nxt = ST_IDLE; // RULE19
               end else begin
                  cnt_nxt = {cnt_r[3:0], rxNib}; // RULE6
                  dig_nxt = 3'(dig_r + 3'h1);
                  pos_nxt  = 8'h00;
                  half_nxt = 1'b0;
                  if (dig_r == 3'(CNT_DIGITS - 3'h1)) begin
                     if (cmd_r == CMD_READ) begin
                        state_nxt = ({cnt_r[3:0], rxNib} == 8'h00) ? ST_IDLE : ST_RB_REQ;
                     end else if ({cnt_r[3:0], rxNib} != 8'h00) begin
                        state_nxt = ST_DATA;
                     end else if (cmd_r == CMD_STAT) begin
                        state_nxt = ST_CLEAR; // RULE18
                     end else begin
                        state_nxt = ST_IDLE; // RULE20
                     end
                  end
               end
            end
         end
         ST_DATA: begin
            if (take) begin
               cnt_nxt = 8'(cnt_r - 8'h01);
               pos_nxt = 8'(pos_r + 8'h01);
               if (cnt_r == 8'h01) begin
                  state_nxt = ST_IDLE; // RULE20
               end
               unique case (cmd_r)
                  CMD_ASCII: begin
                     wrEn_nxt   = 1'b1;
                     wrAddr_nxt = addr_r;
                     wrData_nxt = {1'b0, rxChar[6:0]}; // RULE7
                     addr_nxt   = 16'(addr_r + 16'h0001); // RULE19
                  end
                  CMD_STAT: begin
                     // Characters past the message area are consumed, not stored
                     if (pos_r < STATUS_LEN) begin // RULE15
                        wrEn_nxt   = 1'b1;
                        wrAddr_nxt = 16'(STATUS_BASE + {8'h00, STATUS_COL_OFS}
                                         + {8'h00, pos_r}); // RULE16
                        wrData_nxt = {1'b0, rxChar[6:0]};
                     end
                  end
                  default: begin
                     if (!rxIsHex) begin
                        state_nxt = ST_IDLE; // RULE19
                     end else if (!half_r) begin
                        hiNib_nxt = rxNib;
                        half_nxt  = 1'b1;
                     end else begin
                        wrEn_nxt   = 1'b1; // RULE9
                        wrAddr_nxt = addr_r;
                        wrData_nxt = {hiNib_r, rxNib};
                        addr_nxt   = 16'(addr_r + 16'h0001);
                        half_nxt   = 1'b0;
                     end
                  end
               endcase
            end
         end
         ST_CLEAR: begin
            wrEn_nxt   = 1'b1; // RULE18
            wrAddr_nxt = 16'(STATUS_BASE + {8'h00, STATUS_COL_OFS} + {8'h00, pos_r});
            wrData_nxt = CH_SPACE;
            pos_nxt    = 8'(pos_r + 8'h01);
            if (pos_r == 8'(STATUS_LEN - 8'h01)) begin
               state_nxt = ST_IDLE;
            end
         end
         ST_RB_REQ: begin
            rdReq_nxt = 1'b1; // RULE13
            state_nxt = ST_RB_WAIT;
         end
         ST_RB_WAIT: begin
            if (memRdValid) begin
               rbByte_nxt  = memRdData;
               txChar_nxt  = encChar; // RULE14
               txValid_nxt = 1'b1;
               state_nxt   = ST_RB_HI;
            end
         end
         ST_RB_HI: begin
            if (txReady) begin
               txChar_nxt = encChar; // RULE14
               state_nxt  = ST_RB_LO;
            end
         end
         ST_RB_LO: begin
            if (txReady) begin
               txValid_nxt = 1'b0;
               addr_nxt    = 16'(addr_r + 16'h0001);
               cnt_nxt     = 8'(cnt_r - 8'h01);
               state_nxt   = (cnt_r == 8'h01) ? ST_IDLE : ST_RB_REQ;
            end
         end
         ST_COMMIT: begin
            // Receiver stalls until the store finishes
            if (commitDone) begin
               offLine_nxt = 1'b0; // RULE12
               local_nxt   = 1'b1;
               state_nxt   = ST_IDLE;
            end
         end
      endcase
      rxReady_nxt = (state_nxt == ST_IDLE) || (state_nxt == ST_ESC) || (state_nxt == ST_ESC_R)
                    || (state_nxt == ST_COL) || (state_nxt == ST_ROW) || (state_nxt == ST_PAGE)
                    || (state_nxt == ST_ADDR) || (state_nxt == ST_CNT)
                    || (state_nxt == ST_DATA);
   end

   // State registers
   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         state_r     <= ST_IDLE;
         cmd_r       <= CMD_ASCII;
         dig_r       <= 3'h0;
         addr_r      <= 16'h0000;
         cnt_r       <= 8'h00;
         pos_r       <= 8'h00;
         hiNib_r     <= 4'h0;
         half_r      <= 1'b0;
         rbByte_r    <= 8'h00;
         col_r       <= 7'h00;
         rxReady_r   <= 1'b1;
         passValid_r <= 1'b0;
         passChar_r  <= 8'h00;
         escValid_r  <= 1'b0;
         escCode_r   <= 8'h00;
         curValid_r  <= 1'b0;
         curCol_r    <= 7'h00;
         curRow_r    <= 7'h00;
         pgValid_r   <= 1'b0;
         pgSel_r     <= 7'h00;
         wrEn_r      <= 1'b0;
         wrAddr_r    <= 16'h0000;
         wrData_r    <= 8'h00;
         rdReq_r     <= 1'b0;
         txValid_r   <= 1'b0;
         txChar_r    <= 8'h00;
         restart_r   <= 1'b0;
         commit_r    <= 1'b0;
         offLine_r   <= 1'b0;
         local_r     <= 1'b0;
      end else begin
         state_r     <= state_nxt;
         cmd_r       <= cmd_nxt;
         dig_r       <= dig_nxt;
         addr_r      <= addr_nxt;
         cnt_r       <= cnt_nxt;
         pos_r       <= pos_nxt;
         hiNib_r     <= hiNib_nxt;
         half_r      <= half_nxt;
         rbByte_r    <= rbByte_nxt;
         col_r       <= col_nxt;
         rxReady_r   <= rxReady_nxt;
         passValid_r <= passValid_nxt;
         passChar_r  <= passChar_nxt;
         escValid_r  <= escValid_nxt;
         escCode_r   <= escCode_nxt;
         curValid_r  <= curValid_nxt;
         curCol_r    <= curCol_nxt;
         curRow_r    <= curRow_nxt;
         pgValid_r   <= pgValid_nxt;
         pgSel_r     <= pgSel_nxt;
         wrEn_r      <= wrEn_nxt;
         wrAddr_r    <= wrAddr_nxt;
         wrData_r    <= wrData_nxt;
         rdReq_r     <= rdReq_nxt;
         txValid_r   <= txValid_nxt;
         txChar_r    <= txChar_nxt;
         restart_r   <= restart_nxt;
         commit_r    <= commit_nxt;
         offLine_r   <= offLine_nxt;
         local_r     <= local_nxt;
      end
   end

   // Outputs straight from flops
   assign rxReady      = rxReady_r;
   assign passValid    = passValid_r;
   assign passChar     = passChar_r;
   assign escFuncValid = escValid_r;
   assign escFuncCode  = escCode_r;
   assign cursorValid  = curValid_r;
   assign cursorCol    = curCol_r;
   assign cursorRow    = curRow_r;
   assign pageValid    = pgValid_r;
   assign pageSel      = pgSel_r;
   assign memWrEn      = wrEn_r;
   assign memWrAddr    = wrAddr_r;
   assign memWrData    = wrData_r;
   assign memRdReq     = rdReq_r;
   assign memRdAddr    = addr_r;
   assign txValid      = txValid_r;
   assign txChar       = txChar_r;
   assign xmitMode     = txValid_r;
   assign restartReq   = restart_r;
   assign commitReq    = commit_r;
   assign offLine      = offLine_r;
   assign localMode    = local_r;
endmodule

// [design/rci_pkg.sv]
// Shared constants and types for the remote configuration escape interpreter
package rci_pkg;
   localparam logic [7:0]  CH_ESC        = 8'h1b;
   localparam logic [7:0]  CH_R          = 8'h52;
   localparam logic [7:0]  CH_ASCII_WR   = 8'h41;  // 'A'
   localparam logic [7:0]  CH_HEX_WR     = 8'h48;  // 'H'
   localparam logic [7:0]  CH_RESTART    = 8'h43;  // 'C'
   localparam logic [7:0]  CH_COMMIT     = 8'h50;  // 'P'
   localparam logic [7:0]  CH_READBACK   = 8'h54;  // 'T'
   localparam logic [7:0]  CH_STATUS_WR  = 8'h53;  // 'S'
   localparam logic [7:0]  CH_CURSOR     = 8'h22;  // '"'
   localparam logic [7:0]  CH_PAGE       = 8'h24;  // '$'
   localparam logic [7:0]  CH_SPACE      = 8'h20;
   localparam logic [7:0]  PARAM_BIAS    = 8'h20;  // 32 added to cursor and page values
   localparam logic [7:0]  STATUS_COL_OFS = 8'h10; // 16 positions kept for the indicator
   localparam logic [7:0]  STATUS_LEN    = 8'h38;  // 56 message positions
   localparam logic [2:0]  ADDR_DIGITS   = 3'h4;
   localparam logic [2:0]  CNT_DIGITS    = 3'h2;
   localparam logic [15:0] STATUS_BASE_DEF = 16'h0000;
   localparam int          CHARS_PER_LINE_DEF = 80;
   localparam int          MAX_ROW_DEF   = 95;
   localparam int          MAX_PAGES_DEF = 25;

   typedef enum logic [1:0] {
      CMD_ASCII, CMD_HEX, CMD_READ, CMD_STAT
   } rci_cmd_t;

   typedef enum logic [3:0] {
      ST_IDLE, ST_ESC, ST_ESC_R, ST_COL, ST_ROW, ST_PAGE, ST_ADDR, ST_CNT,
      ST_DATA, ST_CLEAR, ST_RB_REQ, ST_RB_WAIT, ST_RB_HI, ST_RB_LO, ST_COMMIT
   } rci_state_t;
endpackage

// [tb/rci_far_model.sv]
// Memory and nonvolatile storage responder at the far side
`timescale 1ns/10ps
module rci_far_model #(
   parameter int COMMIT_LAT = 4
)(
   // Clock and reset
   input  wire logic        clock,
   input  wire logic        arst_n,
   // Requests
   input  wire logic        memRdReq,
   input  wire logic [15:0] memRdAddr,
   input  wire logic        commitReq,
   // Answers
   output logic             memRdValid,
   output logic [7:0]       memRdData,
   output logic             commitDone
);
   int waitN;
   // Data inverts outside the pulse so a stale byte is never read as fresh
   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         memRdValid <= 1'b0;
         memRdData  <= 8'h00;
         commitDone <= 1'b0;
         waitN      <= 0;
      end else begin
         memRdValid <= memRdReq;
         memRdData  <= memRdReq ? memRdAddr[7:0] + 8'ha5 : ~memRdData;
         commitDone <= (waitN == 1);
         waitN      <= commitReq ? COMMIT_LAT : (waitN > 0 ? waitN - 1 : 0);
      end
   end
endmodule

// [tb/rci_interp_chk.sv]
// Port-level checker for the escape interpreter
`timescale 1ns/10ps
module rci_interp_chk
   import rci_pkg::*;
#(
   parameter int CHARS_PER_LINE = CHARS_PER_LINE_DEF,
   parameter int MAX_ROW        = MAX_ROW_DEF,
   parameter int MAX_PAGES      = MAX_PAGES_DEF
)(
   // Clock and reset
   input wire logic       clock,
   input wire logic       arst_n,
   // Receive side
   input wire logic       rxValid,
   input wire logic       rxReady,
   input wire logic       passValid,
   // Parameters decoded
   input wire logic       cursorValid,
   input wire logic [6:0] cursorCol,
   input wire logic [6:0] cursorRow,
   input wire logic       pageValid,
   input wire logic [6:0] pageSel,
   // Transmit and control
   input wire logic       memWrEn,
   input wire logic       txValid,
   input wire logic [7:0] txChar,
   input wire logic       txReady,
   input wire logic       xmitMode,
   input wire logic       restartReq,
   input wire logic       commitReq,
   input wire logic       commitDone,
   input wire logic       offLine,
   input wire logic       localMode
);
   default clocking cb @(posedge clock); endclocking
   default disable iff (!arst_n);
   // Output timing tied to its cause
   xmit_mode_a: assert property (xmitMode == txValid && (!xmitMode || !rxReady))
      else $error("xmit level off");
   pass_take_a: assert property (passValid |-> $past(rxValid && rxReady))
      else $error("pass without take");
   tx_hold_a: assert property (txValid && !txReady |=> txValid && $stable(txChar))
      else $error("tx dropped early");
   tx_hex_a: assert property (txValid |-> txChar inside {[8'h30:8'h39], [8'h41:8'h46]})
      else $error("tx not hex");
   col_range_a: assert property (cursorValid |-> cursorCol < CHARS_PER_LINE && cursorRow <= MAX_ROW)
      else $error("cursor out of range");
   page_range_a: assert property (pageValid |-> pageSel >= 1 && pageSel <= MAX_PAGES)
      else $error("page out of range");
   commit_off_a: assert property (commitReq |-> offLine && !restartReq)
      else $error("commit not off-line");
   off_refuse_a: assert property (offLine |-> !rxReady) else $error("rx taken off-line");
   commit_end_a: assert property (offLine && commitDone |=> !offLine && localMode)
      else $error("commit end wrong");
   // Main scenarios reached
   cover property (commitReq);
   cover property (txValid && txReady);
   cover property (memWrEn);
endmodule
bind rci_interp rci_interp_chk #(.CHARS_PER_LINE(CHARS_PER_LINE), .MAX_ROW(MAX_ROW),
   .MAX_PAGES(MAX_PAGES)) i_rci_interp_chk (.*);

// [tb/tb.sv]
// Self-checking bench for the escape interpreter
`timescale 1ns/10ps
module tb;
   import rci_pkg::*;
   logic        clock = 1'b0, arst_n = 1'b0, rxValid = 1'b0, txReady = 1'b1, localKey = 1'b0;
   logic [7:0]  rxChar = 8'h00, passChar, escFuncCode, memWrData, txChar, memRdData;
   logic [6:0]  cursorCol, cursorRow, pageSel;
   logic [15:0] memWrAddr, memRdAddr;
   logic        rxReady, passValid, escFuncValid, cursorValid, pageValid, memWrEn, memRdReq;
   logic        memRdValid, txValid, xmitMode, restartReq, commitReq, commitDone, offLine;
   logic        localMode;
   int          n_fail = 0, cmp_count = 0, nRst = 0, nCom = 0;
   logic [23:0] wrQ[$];
   logic [7:0]  chQ[$];
   rci_interp i_rci_interp (.*);
   rci_far_model i_rci_far_model (.*);
   // 200 MHz clock
   initial forever #2.5 clock = ~clock;
   // Record outputs in order; pre-edge values match what the design launched
   always @(posedge clock) begin
      if (memWrEn === 1'b1) wrQ.push_back({memWrAddr, memWrData});
      if (txValid === 1'b1 && txReady === 1'b1) chQ.push_back(txChar);
      if (passValid === 1'b1) chQ.push_back(passChar);
      if (escFuncValid === 1'b1) chQ.push_back(escFuncCode);
      if (restartReq === 1'b1) nRst++;
      if (commitReq === 1'b1) nCom++;
   end
   task automatic chk(input logic [23:0] got, input logic [23:0] exp);
      cmp_count++;
      if (got !== exp) begin
         n_fail++;
         $display("ERROR %0t got %h expected %h", $time, got, exp);
      end
   endtask
   // Characters held until taken; long tail lets clears and waits finish
   task automatic send(input string s);
      for (int i = 0; i < s.len(); i++) begin
         rxValid <= 1'b1;
         rxChar  <= s[i];
         do @(posedge clock); while (rxReady !== 1'b1);
      end
      rxValid <= 1'b0;
      repeat (70) @(posedge clock);
   endtask
   task automatic t_ascii();
      send("\033RA010002A\302x");
      chk(wrQ.pop_front(), 24'h010041);
      chk(wrQ.pop_front(), 24'h010142);
      chk(chQ.pop_front(), 8'h78);
      $display("ascii write done");
   endtask
   task automatic t_hex();
      send("\033RH020004FE09");
      chk(wrQ.pop_front(), 24'h0200fe);
      chk(wrQ.pop_front(), 24'h020109);
      chk(wrQ.size(), 0);
      $display("hex write done");
   endtask
   task automatic t_stat();
      send("\033RS02hi");
      chk(wrQ.pop_front(), 24'h001068);
      chk(wrQ.pop_front(), 24'h001169);
      send("\033RS00");
      for (int i = 0; i < 56; i++) chk(wrQ.pop_front(), {16'h0010 + i[15:0], 8'h20});
      chk(wrQ.size(), 0);
      localKey <= 1'b1;
      @(posedge clock);
      localKey <= 1'b0;
      repeat (62) @(posedge clock);
      chk(wrQ.pop_front(), 24'h001020);
      chk(wrQ.size(), 55);
      wrQ.delete();
      $display("status write done");
   endtask
   task automatic t_read();
      txReady <= 1'b0;
      send("\033RT031201");
      txReady <= 1'b1;
      repeat (10) @(posedge clock);
      chk(chQ.pop_front(), 8'h42);
      chk(chQ.pop_front(), 8'h37);
      $display("readback done");
   endtask
   task automatic t_cmd();
      send("\033RP");
      chk(nCom, 1);
      chk({offLine, localMode}, 2'b01);
      send("\033RC");
      chk({nRst[11:0], nCom[11:0]}, {12'd1, 12'd1});
      chk(localMode, 1'b0);
      send("\033\042%*\033$#\033J");
      chk({cursorCol, cursorRow}, {7'd5, 7'd10});
      chk(pageSel, 3);
      send("\033\042p*");
      chk(cursorCol, 7'd5);
      chk(chQ.pop_front(), 8'h4a);
      $display("commands done");
   endtask
   task automatic conclude();
      $display("compares %0d mismatches %0d", cmp_count, n_fail);
      if (n_fail == 0 && cmp_count > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask
   // Reset for three cycles, then the scenarios
   initial begin
      repeat (3) @(posedge clock);
      arst_n <= 1'b1;
      @(posedge clock);
      t_ascii();
      t_hex();
      t_stat();
      t_read();
      t_cmd();
      conclude();
   end
   // Scenarios need under 800 cycles; cut a hang at 6000
   initial begin
      #30000;
      n_fail++;
      conclude();
   end
endmodule
